/* bench/pif_event_src.sv */
`timescale 1ns/1ps
// ==========================================================
// Peripheral event sources
module pif_event_src (
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  // Request from the bench, one bit per source, struct order
  input  wire logic [15:0]     fire,
  // Strobes toward the flag block
  output pif_pkg::pif_events_s events
);
  // Registered, so each source strobes one clock behind fire and for as many clocks as fire is held
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      events <= '0;
    end else begin
      events <= pif_pkg::pif_events_s'(fire);
    end
  end
endmodule // pif_event_src

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic                 clk_sys;
  logic                 rst_n;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [7:0]           paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 peripheral_irq;
  logic [7:0]           core_flags1;
  logic [7:0]           core_enables2;
  logic [7:0]           core_enables3;
  logic [15:0]          fire;
  pif_pkg::pif_events_s events;
  pif_pkg::pif_modes_s  modes;
  int                   errors;
  int                   cmp_count;
  int                   cycles;
  logic [31:0]          q;
  logic                 err;
  logic [7:0]           exp2 [5];

  pif_event_src src (.clk_sys(clk_sys), .rst_n(rst_n), .fire(fire), .events(events));
  pif_irq_flags dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events),
    .modes(modes), .core_flags1(core_flags1), .core_enables2(core_enables2), .core_enables3(core_enables3),
    .peripheral_irq(peripheral_irq));

  // ==========================================================
  // Clock and watchdog
  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      finish_test();
    end
  end

  // ==========================================================
  // Tasks
  task automatic finish_test;
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Holds the request until pready is sampled high at a rising edge; the answer is taken at that edge
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'h1;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    // Read right at the edge, outputs still show what that edge samples; only the watchdog ends a hang
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'h1);
    q   = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'h1, a, {24'h0, d});
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    apb(1'h0, a, 32'h0);
    check(name, q, {24'h0, exp});
  endtask

  task automatic pulse(input logic [15:0] v);
    @(posedge clk_sys);
    fire <= v;
    @(posedge clk_sys);
    fire <= 16'h0;
    repeat (2) @(posedge clk_sys);
  endtask

  // Request is registered twice behind its causes, so allow three edges
  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge clk_sys);
    #1;
    check("peripheral_irq", {31'h0, peripheral_irq}, {31'h0, exp});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, fire} = '0;
    {core_flags1, core_enables2, core_enables3} = '0;
    modes = '0;
    {errors, cmp_count, cycles} = '0;
    exp2 = '{8'h80, 8'hC0, 8'hC8, 8'hCC, 8'hCE};
    rst_n = 1'h0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'h1;
    rd_chk("flags2", pif_pkg::OFF_FLAGS2, 8'h00);
    rd_chk("flags3", pif_pkg::OFF_FLAGS3, 8'h00);
    rd_chk("enables1", pif_pkg::OFF_ENABLES1, 8'h00);
    wr(pif_pkg::OFF_ENABLES1, 8'hFF);
    rd_chk("enables1", pif_pkg::OFF_ENABLES1, 8'h7B);
    wr(pif_pkg::OFF_ENABLES1, 8'h00);
    // Sources strobe with every enable closed: polling must still see them
    for (int i = 0; i < 5; i++) begin
      pulse(16'h8000 >> i);
      rd_chk("flags2", pif_pkg::OFF_FLAGS2, exp2[i]);
    end
    wr(pif_pkg::OFF_FLAGS2, 8'h00);
    wr(pif_pkg::OFF_FLAGS2, 8'h31);
    rd_chk("flags2", pif_pkg::OFF_FLAGS2, 8'h00);
    modes <= '{pif_pkg::PIF_CCP_CAPTURE, pif_pkg::PIF_CCP_CAPTURE, 1'h1};
    pulse(16'h0435);
    rd_chk("flags3", pif_pkg::OFF_FLAGS3, 8'h4F);
    wr(pif_pkg::OFF_FLAGS3, 8'hB0);
    rd_chk("flags3", pif_pkg::OFF_FLAGS3, 8'h00);
    modes <= '{pif_pkg::PIF_CCP_COMPARE, pif_pkg::PIF_CCP_COMPARE, 1'h0};
    pulse(16'h040A);
    rd_chk("flags3", pif_pkg::OFF_FLAGS3, 8'h06);
    wr(pif_pkg::OFF_FLAGS3, 8'h00);
    modes <= '{pif_pkg::PIF_CCP_PWM, pif_pkg::PIF_CCP_PWM, 1'h1};
    pulse(16'h001E);
    rd_chk("flags3", pif_pkg::OFF_FLAGS3, 8'h00);
    modes <= '0;
    pulse(16'h001E);
    rd_chk("flags3", pif_pkg::OFF_FLAGS3, 8'h00);
    pulse(16'h0200);
    wr(pif_pkg::OFF_FLAGS3, 8'h00);
    rd_chk("flags3", pif_pkg::OFF_FLAGS3, 8'h20);
    pulse(16'h0100);
    rd_chk("flags3", pif_pkg::OFF_FLAGS3, 8'h00);
    pulse(16'h0080);
    wr(pif_pkg::OFF_FLAGS3, 8'h00);
    rd_chk("flags3", pif_pkg::OFF_FLAGS3, 8'h10);
    pulse(16'h0040);
    rd_chk("flags3", pif_pkg::OFF_FLAGS3, 8'h00);
    apb(1'h0, 8'h10, 32'h0);
    check("pslverr", {31'h0, err}, 32'h1);
    check("unmapped", q, 32'h0);
    // Request gating: flag, enable, global and the peripheral or priority path
    core_enables2 <= 8'h02;
    // Event and software clear meet at the same edge: the event must win
    fork
      wr(pif_pkg::OFF_FLAGS2, 8'h00);
      pulse(16'h0800);
    join
    rd_chk("flags2", pif_pkg::OFF_FLAGS2, 8'h02);
    wr(pif_pkg::OFF_CTRL, 8'h02);
    irq_chk(1'h0);
    wr(pif_pkg::OFF_CTRL, 8'h03);
    irq_chk(1'h1);
    wr(pif_pkg::OFF_CTRL, 8'h06);
    irq_chk(1'h1);
    wr(pif_pkg::OFF_CTRL, 8'h05);
    irq_chk(1'h0);
    wr(pif_pkg::OFF_CTRL, 8'h03);
    wr(pif_pkg::OFF_FLAGS2, 8'h00);
    irq_chk(1'h0);
    core_flags1 <= 8'h01;
    wr(pif_pkg::OFF_ENABLES1, 8'h01);
    irq_chk(1'h1);
    wr(pif_pkg::OFF_ENABLES1, 8'h00);
    irq_chk(1'h0);
    core_enables3 <= 8'h01;
    pulse(16'h0001);
    irq_chk(1'h1);
    // Reset in mid-run must wipe flags and enables again
    wr(pif_pkg::OFF_ENABLES1, 8'h7B);
    @(posedge clk_sys);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'h1;
    rd_chk("flags3", pif_pkg::OFF_FLAGS3, 8'h00);
    rd_chk("enables1", pif_pkg::OFF_ENABLES1, 8'h00);
    irq_chk(1'h0);
    finish_test();
  end
endmodule // testbench

/* hdl/pif_irq_flags.sv */
`timescale 1ns/1ps
// Summary of operation
// - Oscillator failure sets flag 2 bit 7; software clears it.
// - Comparator input change sets flag 2 bit 6; software clears it.
// - Flag 2 bits 5:4 and 0 read zero, ignore writes.
// - Bus collision sets flag 2 bit 3; only software clears it.
// - Low supply voltage sets flag 2 bit 2; software clears it.
// - Timer 3 overflow sets flag 2 bit 1; software clears it.
// - LCD frame output sets flag 3 bit 6, only in type-B non-static drive.
// - Serial 2 receive flag is read-only; set on data, cleared by buffer read.
// - Serial 2 transmit flag is read-only; set when empty, cleared by buffer write.
// - Charge time unit event sets flag 3 bit 3; software clears it.
// - Capture mode captures set capture/compare flags at bits 2 and 1.
// - Compare mode matches set capture/compare flags; software clears them.
// - PWM mode never sets a capture/compare flag.
// - Real-time clock event sets flag 3 bit 0; software clears it.
// - Without priority mode, requests need the peripheral enable too.
// - Enable register 1 holds six read/write enables; one enables.
// - Flag 3 bit 7, enable 1 bits 7 and 2 read zero.
// - All implemented flag and enable bits are zero after reset.
// - Flags set on events whatever the enables say.
module pif_irq_flags (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pif_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [pif_pkg::DATA_W-1:0]  pwdata,
  output logic      [pif_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Peripheral events and modes
  input  wire pif_pkg::pif_events_s        events,
  input  wire pif_pkg::pif_modes_s         modes,
  // Flags and enables kept outside this block
  input  wire logic [pif_pkg::REG_W-1:0]   core_flags1,
  input  wire logic [pif_pkg::REG_W-1:0]   core_enables2,
  input  wire logic [pif_pkg::REG_W-1:0]   core_enables3,
  // Request toward the core
  output logic                             peripheral_irq
);

  // ==========================================================
  // Helpers
  function automatic logic [3:0] reg_sel(input logic [pif_pkg::ADDR_W-1:0] a);
    reg_sel = {a == pif_pkg::OFF_CTRL, a == pif_pkg::OFF_ENABLES1,
               a == pif_pkg::OFF_FLAGS3, a == pif_pkg::OFF_FLAGS2};
  endfunction

  function automatic logic ccp_set(input pif_pkg::pif_ccp_mode_e m,
                                   input logic cap, input logic mat);
    case (m)
      pif_pkg::PIF_CCP_CAPTURE: ccp_set = cap;
      pif_pkg::PIF_CCP_COMPARE: ccp_set = mat;
      default:                  ccp_set = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // State
  pif_pkg::pif_state_s st_r;
  pif_pkg::pif_state_s st_nxt;

  logic                        setup_phase;
  logic                        wr_take;
  logic [3:0]                  wr_sel;
  logic [3:0]                  rd_sel;
  logic [pif_pkg::REG_W-1:0]   wdat;
  logic [pif_pkg::REG_W-1:0]   set2;
  logic [pif_pkg::REG_W-1:0]   set3;
  logic [pif_pkg::REG_W-1:0]   rdat;
  logic                        any_pending;
  logic                        gate_open;

  assign setup_phase = psel && !penable;
  // A write lands only at the edge where the answer is sampled
  assign wr_take = psel && penable && st_r.pready && pwrite;
  assign wr_sel  = wr_take ? reg_sel(paddr) : 4'h0;
  assign rd_sel  = reg_sel(paddr);
  assign wdat    = pwdata[pif_pkg::REG_W-1:0];

  // ==========================================================
  // Event decode
  always_comb begin
    set2 = pif_pkg::RST_REG;
    set3 = pif_pkg::RST_REG;
    set2[pif_pkg::F2_OSC_FAIL]   = events.osc_fail;
    set2[pif_pkg::F2_COMPARATOR] = events.comparator_change;
    set2[pif_pkg::F2_BUS_COLL]   = events.bus_collision;
    set2[pif_pkg::F2_LOW_VOLT]   = events.low_voltage;
    set2[pif_pkg::F2_TIMER3_OVF] = events.timer3_overflow;
    // Frame flag is meaningless outside type-B non-static drive
    set3[pif_pkg::F3_LCD_FRAME]  = events.lcd_frame_done && modes.lcd_typeb_nonstatic;
    set3[pif_pkg::F3_CHARGE]     = events.charge_time_event;
    set3[pif_pkg::F3_CAPCOMP2]   = ccp_set(modes.capcomp2_mode, events.capcomp2_capture,
                                           events.capcomp2_match);
    set3[pif_pkg::F3_CAPCOMP1]   = ccp_set(modes.capcomp1_mode, events.capcomp1_capture,
                                           events.capcomp1_match);
    set3[pif_pkg::F3_RTC]        = events.rtc_event;
  end

  // ==========================================================
  // Read mux and request gating
  always_comb begin
    case (rd_sel)
      4'h1:    rdat = st_r.flags2 & pif_pkg::MASK_FLAGS2;
      4'h2:    rdat = st_r.flags3 & pif_pkg::MASK_FLAGS3;
      4'h4:    rdat = st_r.enables1 & pif_pkg::MASK_ENABLES1;
      4'h8:    rdat = st_r.ctrl & pif_pkg::MASK_CTRL;
      default: rdat = pif_pkg::RST_REG;
    endcase
  end

  assign any_pending = |(core_flags1 & st_r.enables1)
                     | |(st_r.flags2 & core_enables2)
                     | |(st_r.flags3 & core_enables3);
  // Priority mode leaves peripheral gating to the priority logic outside
  assign gate_open = st_r.ctrl[pif_pkg::CTRL_GLOBAL] &&
                     (st_r.ctrl[pif_pkg::CTRL_PRIORITY] ||
                      st_r.ctrl[pif_pkg::CTRL_PERIPH]);

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    // Software write first, then hardware set wins in the same cycle
    if (wr_sel[0]) begin
      st_nxt.flags2 = wdat & pif_pkg::MASK_FLAGS2;
    end
    st_nxt.flags2 = st_nxt.flags2 | (set2 & pif_pkg::MASK_FLAGS2);
    if (wr_sel[1]) begin
      st_nxt.flags3 = (st_r.flags3 & ~pif_pkg::MASK_FLAGS3_SW)
                    | (wdat & pif_pkg::MASK_FLAGS3_SW);
    end
    st_nxt.flags3 = st_nxt.flags3 | (set3 & pif_pkg::MASK_FLAGS3_SW);
    if (events.serial2_rx_buffer_read) begin
      st_nxt.flags3[pif_pkg::F3_SER2_RX] = 1'b0;
    end
    if (events.serial2_rx_ready) begin
      st_nxt.flags3[pif_pkg::F3_SER2_RX] = 1'b1;
    end
    if (events.serial2_tx_buffer_write) begin
      st_nxt.flags3[pif_pkg::F3_SER2_TX] = 1'b0;
    end
    if (events.serial2_tx_empty) begin
      st_nxt.flags3[pif_pkg::F3_SER2_TX] = 1'b1;
    end
    if (wr_sel[2]) begin
      st_nxt.enables1 = wdat & pif_pkg::MASK_ENABLES1;
    end
    if (wr_sel[3]) begin
      st_nxt.ctrl = wdat & pif_pkg::MASK_CTRL;
    end
    // Answer one cycle after setup; data is captured at the setup edge
    st_nxt.pready  = setup_phase;
    st_nxt.pslverr = setup_phase && (rd_sel == 4'h0);
    if (setup_phase) begin
      st_nxt.prdata = {{(pif_pkg::DATA_W - pif_pkg::REG_W){1'b0}}, rdat};
    end
    st_nxt.irq = any_pending && gate_open;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata         = st_r.prdata;
  assign pready         = st_r.pready;
  assign pslverr        = st_r.pslverr;
  assign peripheral_irq = st_r.irq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic wr_f2;
  logic wr_f3;
  assign wr_f2 = wr_sel[0];
  assign wr_f3 = wr_sel[1];

  a_osc_fail_set: assert property (events.osc_fail |=> st_r.flags2[pif_pkg::F2_OSC_FAIL])
    else $error("oscillator fail flag not set");

  a_cmp_flag_set: assert property (events.comparator_change |=> st_r.flags2[pif_pkg::F2_COMPARATOR])
    else $error("comparator flag not set");

  a_f2_unimpl_zero: assert property ((st_r.flags2 & ~pif_pkg::MASK_FLAGS2) == 8'h00)
    else $error("unimplemented flag 2 bit set");

  a_bcl_flag_hold: assert property (st_r.flags2[pif_pkg::F2_BUS_COLL] && !wr_f2
                                    |=> st_r.flags2[pif_pkg::F2_BUS_COLL])
    else $error("bus collision flag dropped without write");

  a_lcd_mode_gate: assert property (!modes.lcd_typeb_nonstatic && !st_r.flags3[pif_pkg::F3_LCD_FRAME]
                                    && !wr_f3 |=> !st_r.flags3[pif_pkg::F3_LCD_FRAME])
    else $error("lcd flag set outside type-B mode");

  a_rx_read_clear: assert property (events.serial2_rx_buffer_read && !events.serial2_rx_ready
                                    |=> !st_r.flags3[pif_pkg::F3_SER2_RX])
    else $error("receive flag not cleared by buffer read");

  a_tx_write_clear: assert property (events.serial2_tx_buffer_write && !events.serial2_tx_empty
                                     |=> !st_r.flags3[pif_pkg::F3_SER2_TX])
    else $error("transmit flag not cleared by buffer write");

  a_capture_set: assert property (modes.capcomp1_mode == pif_pkg::PIF_CCP_CAPTURE
                                  && events.capcomp1_capture |=> st_r.flags3[pif_pkg::F3_CAPCOMP1])
    else $error("capture did not set flag");

  a_pwm_no_set: assert property (modes.capcomp2_mode == pif_pkg::PIF_CCP_PWM && !wr_f3
                                 && !st_r.flags3[pif_pkg::F3_CAPCOMP2]
                                 |=> !st_r.flags3[pif_pkg::F3_CAPCOMP2])
    else $error("pwm mode set capture/compare flag");

  a_rtc_poll_set: assert property (events.rtc_event && core_enables3 == 8'h00
                                   |=> st_r.flags3[pif_pkg::F3_RTC])
    else $error("rtc flag not set with enable off");

  a_periph_gate: assert property (!st_r.ctrl[pif_pkg::CTRL_PRIORITY] && !st_r.ctrl[pif_pkg::CTRL_PERIPH]
                                  |=> !peripheral_irq)
    else $error("request passed without peripheral enable");

  a_irq_cause: assert property (peripheral_irq |-> $past(any_pending && gate_open))
    else $error("request without enabled flag");

  a_reset_clear: assert property ($rose(rst_n) |-> st_r.flags2 == 8'h00 && st_r.flags3 == 8'h00
                                  && st_r.enables1 == 8'h00)
    else $error("flags or enables not zero after reset");

  a_apb_answer: assert property (setup_phase |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");

  // ==========================================================
  // Checks: flag register 2

  a_bcl_flag_set: assert property (events.bus_collision |=> st_r.flags2[pif_pkg::F2_BUS_COLL])
    else $error("bus collision flag not set");

  a_lv_flag_set: assert property (events.low_voltage |=> st_r.flags2[pif_pkg::F2_LOW_VOLT])
    else $error("low voltage flag not set");

  a_t3_flag_set: assert property (events.timer3_overflow |=> st_r.flags2[pif_pkg::F2_TIMER3_OVF])
    else $error("timer 3 flag not set");

  a_osc_flag_hold: assert property (st_r.flags2[pif_pkg::F2_OSC_FAIL] && !wr_f2
                                    |=> st_r.flags2[pif_pkg::F2_OSC_FAIL])
    else $error("oscillator fail flag dropped without write");

  a_cmp_flag_hold: assert property (st_r.flags2[pif_pkg::F2_COMPARATOR] && !wr_f2
                                    |=> st_r.flags2[pif_pkg::F2_COMPARATOR])
    else $error("comparator flag dropped without write");

  a_lv_flag_hold: assert property (st_r.flags2[pif_pkg::F2_LOW_VOLT] && !wr_f2
                                   |=> st_r.flags2[pif_pkg::F2_LOW_VOLT])
    else $error("low voltage flag dropped without write");

  a_t3_flag_hold: assert property (st_r.flags2[pif_pkg::F2_TIMER3_OVF] && !wr_f2
                                   |=> st_r.flags2[pif_pkg::F2_TIMER3_OVF])
    else $error("timer 3 flag dropped without write");

  a_f2_sw_clear: assert property (wr_f2 && wdat == 8'h00 && set2 == pif_pkg::RST_REG
                                  |=> st_r.flags2 == 8'h00)
    else $error("software clear of flag 2 failed");

  a_f2_set_wins: assert property (wr_f2 && events.timer3_overflow
                                  |=> st_r.flags2[pif_pkg::F2_TIMER3_OVF])
    else $error("software clear beat a timer 3 event");

  a_f2_no_change: assert property (!wr_f2 && set2 == pif_pkg::RST_REG
                                   |=> $stable(st_r.flags2))
    else $error("flag 2 changed with no event or write");

  a_rd_f2_zero: assert property (setup_phase && rd_sel == 4'h1
                                 |=> prdata[5:4] == 2'h0 && !prdata[0] && prdata[31:8] == 24'h000000)
    else $error("unimplemented flag 2 bits read nonzero");

  // ==========================================================
  // Checks: flag register 3

  a_lcd_flag_set: assert property (events.lcd_frame_done && modes.lcd_typeb_nonstatic
                                   |=> st_r.flags3[pif_pkg::F3_LCD_FRAME])
    else $error("lcd flag not set in type-B mode");

  a_charge_set: assert property (events.charge_time_event |=> st_r.flags3[pif_pkg::F3_CHARGE])
    else $error("charge time flag not set");

  a_rtc_flag_set: assert property (events.rtc_event |=> st_r.flags3[pif_pkg::F3_RTC])
    else $error("rtc flag not set");

  a_capture2_set: assert property (modes.capcomp2_mode == pif_pkg::PIF_CCP_CAPTURE
                                   && events.capcomp2_capture |=> st_r.flags3[pif_pkg::F3_CAPCOMP2])
    else $error("capture 2 did not set flag");

  a_compare1_set: assert property (modes.capcomp1_mode == pif_pkg::PIF_CCP_COMPARE
                                   && events.capcomp1_match |=> st_r.flags3[pif_pkg::F3_CAPCOMP1])
    else $error("compare 1 match did not set flag");

  a_compare2_set: assert property (modes.capcomp2_mode == pif_pkg::PIF_CCP_COMPARE
                                   && events.capcomp2_match |=> st_r.flags3[pif_pkg::F3_CAPCOMP2])
    else $error("compare 2 match did not set flag");

  a_pwm1_no_set: assert property (modes.capcomp1_mode == pif_pkg::PIF_CCP_PWM && !wr_f3
                                  && !st_r.flags3[pif_pkg::F3_CAPCOMP1]
                                  |=> !st_r.flags3[pif_pkg::F3_CAPCOMP1])
    else $error("pwm mode set capture/compare 1 flag");

  a_f3_unimpl_zero: assert property ((st_r.flags3 & ~pif_pkg::MASK_FLAGS3) == 8'h00)
    else $error("unimplemented flag 3 bit set");

  a_rx_ready_set: assert property (events.serial2_rx_ready |=> st_r.flags3[pif_pkg::F3_SER2_RX])
    else $error("receive flag not set on data");

  a_tx_empty_set: assert property (events.serial2_tx_empty |=> st_r.flags3[pif_pkg::F3_SER2_TX])
    else $error("transmit flag not set when empty");

  a_rx_sw_keep: assert property (wr_f3 && !events.serial2_rx_ready && !events.serial2_rx_buffer_read
                                 |=> $stable(st_r.flags3[pif_pkg::F3_SER2_RX]))
    else $error("software write changed receive flag");

  a_tx_sw_keep: assert property (wr_f3 && !events.serial2_tx_empty && !events.serial2_tx_buffer_write
                                 |=> $stable(st_r.flags3[pif_pkg::F3_SER2_TX]))
    else $error("software write changed transmit flag");

  a_charge_hold: assert property (st_r.flags3[pif_pkg::F3_CHARGE] && !wr_f3
                                  |=> st_r.flags3[pif_pkg::F3_CHARGE])
    else $error("charge time flag dropped without write");

  a_rd_f3_zero: assert property (setup_phase && rd_sel == 4'h2
                                 |=> !prdata[7] && prdata[31:8] == 24'h000000)
    else $error("unimplemented flag 3 bit read nonzero");

  // ==========================================================
  // Checks: enables, request and reset

  a_en1_unimpl_zero: assert property ((st_r.enables1 & ~pif_pkg::MASK_ENABLES1) == 8'h00)
    else $error("unimplemented enable bit set");

  a_en1_write: assert property (wr_sel[2] |=> st_r.enables1 == ($past(wdat) & pif_pkg::MASK_ENABLES1))
    else $error("enable write did not land");

  a_en1_hold: assert property (!wr_sel[2] |=> $stable(st_r.enables1))
    else $error("enables changed without write");

  a_rd_en1_zero: assert property (setup_phase && rd_sel == 4'h4
                                  |=> !prdata[7] && !prdata[2])
    else $error("unimplemented enable bit read nonzero");

  a_irq_t3_path: assert property (st_r.flags2[pif_pkg::F2_TIMER3_OVF] && core_enables2[pif_pkg::F2_TIMER3_OVF]
                                  && st_r.ctrl[pif_pkg::CTRL_GLOBAL] && st_r.ctrl[pif_pkg::CTRL_PERIPH]
                                  |=> peripheral_irq)
    else $error("enabled timer 3 flag raised no request");

  a_irq_prio_path: assert property (st_r.flags2[pif_pkg::F2_TIMER3_OVF] && core_enables2[pif_pkg::F2_TIMER3_OVF]
                                    && st_r.ctrl[pif_pkg::CTRL_GLOBAL] && st_r.ctrl[pif_pkg::CTRL_PRIORITY]
                                    |=> peripheral_irq)
    else $error("priority mode blocked an enabled request");

  a_irq_no_global: assert property (!st_r.ctrl[pif_pkg::CTRL_GLOBAL] |=> !peripheral_irq)
    else $error("request passed without global enable");

  a_irq_none_pending: assert property ((core_flags1 & st_r.enables1) == 8'h00
                                       && (st_r.flags2 & core_enables2) == 8'h00
                                       && (st_r.flags3 & core_enables3) == 8'h00 |=> !peripheral_irq)
    else $error("request with no enabled flag");

  a_reset_outputs: assert property ($rose(rst_n) |-> !peripheral_irq && !pready && !pslverr
                                    && st_r.ctrl == 8'h00)
    else $error("outputs or control not zero after reset");

  // ==========================================================
  // Coverage
  c_irq_raised: cover property (!peripheral_irq ##1 peripheral_irq);
  c_rx_cycle: cover property (events.serial2_rx_ready ##[1:20] events.serial2_rx_buffer_read);
  c_sw_clear: cover property (st_r.flags2[pif_pkg::F2_LOW_VOLT] && wr_f2 ##1
                              !st_r.flags2[pif_pkg::F2_LOW_VOLT]);
  c_set_beats_clear: cover property (wr_f2 && events.timer3_overflow);
  c_prio_path: cover property (st_r.ctrl[pif_pkg::CTRL_PRIORITY] && peripheral_irq);

endmodule // pif_irq_flags

/* hdl/pif_pkg.sv */
package pif_pkg;

  // ==========================================================
  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_FLAGS2   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FLAGS3   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ENABLES1 = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h0C;

  // ==========================================================
  // Field positions
  localparam int unsigned F2_OSC_FAIL   = 7;
  localparam int unsigned F2_COMPARATOR = 6;
  localparam int unsigned F2_BUS_COLL   = 3;
  localparam int unsigned F2_LOW_VOLT   = 2;
  localparam int unsigned F2_TIMER3_OVF = 1;
  localparam int unsigned F3_LCD_FRAME  = 6;
  localparam int unsigned F3_SER2_RX    = 5;
  localparam int unsigned F3_SER2_TX    = 4;
  localparam int unsigned F3_CHARGE     = 3;
  localparam int unsigned F3_CAPCOMP2   = 2;
  localparam int unsigned F3_CAPCOMP1   = 1;
  localparam int unsigned F3_RTC        = 0;
  localparam int unsigned CTRL_PERIPH   = 0;
  localparam int unsigned CTRL_GLOBAL   = 1;
  localparam int unsigned CTRL_PRIORITY = 2;

  // ==========================================================
  // Implemented and software-writable bits
  localparam logic [REG_W-1:0] MASK_FLAGS2    = 8'hCE;
  localparam logic [REG_W-1:0] MASK_FLAGS3    = 8'h7F;
  localparam logic [REG_W-1:0] MASK_FLAGS3_SW = 8'h4F;
  localparam logic [REG_W-1:0] MASK_ENABLES1  = 8'h7B;
  localparam logic [REG_W-1:0] MASK_CTRL      = 8'h07;

  // ==========================================================
  // Reset values
  localparam logic [REG_W-1:0] RST_REG = 8'h00;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PIF_CCP_OFF,
    PIF_CCP_CAPTURE,
    PIF_CCP_COMPARE,
    PIF_CCP_PWM
  } pif_ccp_mode_e;

  typedef struct packed {
    logic osc_fail;
    logic comparator_change;
    logic bus_collision;
    logic low_voltage;
    logic timer3_overflow;
    logic lcd_frame_done;
    logic serial2_rx_ready;
    logic serial2_rx_buffer_read;
    logic serial2_tx_empty;
    logic serial2_tx_buffer_write;
    logic charge_time_event;
    logic capcomp1_capture;
    logic capcomp1_match;
    logic capcomp2_capture;
    logic capcomp2_match;
    logic rtc_event;
  } pif_events_s;

  typedef struct packed {
    pif_ccp_mode_e capcomp1_mode;
    pif_ccp_mode_e capcomp2_mode;
    logic          lcd_typeb_nonstatic;
  } pif_modes_s;

  typedef struct packed {
    logic [REG_W-1:0]  flags2;
    logic [REG_W-1:0]  flags3;
    logic [REG_W-1:0]  enables1;
    logic [REG_W-1:0]  ctrl;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
  } pif_state_s;

endpackage
